// file: pqu_pkg.sv
package pqu_pkg;

  // ----------------------------------------------------------------
  // build options and encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STYLE_ARRAY = 2'h0,
    STYLE_BOOTH = 2'h1,
    STYLE_ITER  = 2'h2
  } pqu_style_t;

  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_PROD_REG   = 4'h1,
    OP_PROD_S     = 4'h2,
    OP_PROD_U     = 4'h3,
    OP_ACC_S      = 4'h4,
    OP_ACC_U      = 4'h5,
    OP_DED_S      = 4'h6,
    OP_DED_U      = 4'h7,
    OP_QUO_S      = 4'h8,
    OP_QUO_U      = 4'h9,
    OP_MOVE_UP    = 4'hA,
    OP_MOVE_BT    = 4'hB,
    OP_PAIR_SHIFT = 4'hC
  } pqu_op_t;

  typedef enum logic [1:0] {
    ACC_NONE = 2'h0,
    ACC_ADD  = 2'h1,
    ACC_SUB  = 2'h2
  } pqu_acc_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_RUN  = 2'h1,
    SEQ_PAD  = 2'h3
  } pqu_seq_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0,
    ENG_RUN  = 2'h1,
    ENG_FIX  = 2'h3,
    ENG_FIX2 = 2'h2
  } pqu_eng_t;

  // operand size classes
  localparam logic [1:0] CLS_8  = 2'h0;
  localparam logic [1:0] CLS_16 = 2'h1;
  localparam logic [1:0] CLS_24 = 2'h2;
  localparam logic [1:0] CLS_32 = 2'h3;

  // ----------------------------------------------------------------
  // sizes and timing counts (pipeline clocks)
  // ----------------------------------------------------------------
  localparam int unsigned NPAIR = 4;
  localparam int unsigned DEPTH = 8;
  localparam logic [2:0] ARR_LAT       = 3'h5;
  localparam logic [2:0] ARR_REP       = 3'h1;
  localparam logic [2:0] BTH_PAIR_LAT1 = 3'h2;
  localparam logic [2:0] BTH_PAIR_LAT2 = 3'h3;
  localparam logic [2:0] BTH_PAIR_REP1 = 3'h1;
  localparam logic [2:0] BTH_PAIR_REP2 = 3'h2;
  localparam logic [2:0] BTH_REG_LAT1  = 3'h5;
  localparam logic [2:0] BTH_REG_LAT2  = 3'h6;
  localparam logic [2:0] BTH_REG_REP1  = 3'h2;
  localparam logic [2:0] BTH_REG_REP2  = 3'h3;
  localparam logic [2:0] MOVE_LAT      = 3'h1;
  localparam logic [2:0] ITER_REG_XTRA = 3'h3;
  localparam logic [2:0] ITER_ACC_PAD  = 3'h1;
  localparam logic [2:0] DIV_PAD_ARR   = 3'h2;
  localparam logic [2:0] DIV_PAD_BTH   = 3'h1;
  localparam logic [2:0] DIV_PAD_ITER  = 3'h0;
  localparam logic [5:0] FULL_STEPS    = 6'h20;
  localparam logic [5:0] SKIP_8        = 6'h17;
  localparam logic [5:0] SKIP_16       = 6'h0F;
  localparam logic [5:0] SKIP_24       = 6'h07;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    pqu_op_t     op;
    logic [1:0]  pair;
    logic [31:0] primary_operand;
    logic [31:0] secondary_operand;
  } pqu_issue_t;

  typedef struct packed {
    pqu_issue_t  iss;
    logic [1:0]  pcls;
    logic [1:0]  scls;
  } pqu_slot_t;

  typedef struct packed {
    logic        valid;
    logic        to_reg;
    logic [1:0]  pair;
    pqu_acc_t    acc;
    logic [31:0] up;
    logic [31:0] bt;
  } pqu_rec_t;

  typedef pqu_rec_t [DEPTH-1:0] pqu_line_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } pqu_wb_t;

endpackage

// file: pqu_width.sv
`timescale 1ns/1ps
// size class of an operand from its sign-extension depth
module pqu_width (
  input  wire logic [31:0] i_value,
  input  wire logic        i_signed,
  output logic      [1:0]  o_cls
);
  logic ext;
  logic f8;
  logic f16;
  logic f24;

  // sign-extension depth class
  // unsigned forms count as zero-extended
  assign ext = i_signed & i_value[31];
  assign f8  = (i_value[31:8] == {24{ext}}) & (~i_signed | (i_value[7] == ext));
  assign f16 = (i_value[31:16] == {16{ext}}) & (~i_signed | (i_value[15] == ext));
  assign f24 = (i_value[31:24] == {8{ext}}) & (~i_signed | (i_value[23] == ext));
  assign o_cls = f8 ? pqu_pkg::CLS_8 : f16 ? pqu_pkg::CLS_16 :
                 f24 ? pqu_pkg::CLS_24 : pqu_pkg::CLS_32;
endmodule

// file: pqu_iter.sv
`timescale 1ns/1ps
// one bit per clock shift-add product and restoring quotient engine
module pqu_iter (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic        i_div,
  input  wire logic        i_signed,
  input  wire logic [31:0] i_a,
  input  wire logic [31:0] i_b,
  input  wire logic [5:0]  i_steps,
  input  wire logic [5:0]  i_skip,
  input  wire logic        i_two_fix,
  output logic             o_done,
  output logic      [31:0] o_up,
  output logic      [31:0] o_bt
);
  pqu_pkg::pqu_eng_t st_q, st_d;
  logic [32:0] up_q, up_d;
  logic [31:0] bt_q, bt_d, m_q, m_d;
  logic [5:0]  cnt_q, cnt_d;
  logic        nq_q, nq_d, nr_q, nr_d, div_q, div_d, two_q, two_d, done_q, done_d;
  logic [31:0] ma, mb;
  logic [32:0] s, r2, df;
  logic [63:0] neg;

  // magnitudes and one step of each algorithm
  assign ma  = (i_signed & i_a[31]) ? 32'(-i_a) : i_a;
  assign mb  = (i_signed & i_b[31]) ? 32'(-i_b) : i_b;
  assign s   = bt_q[0] ? ({1'b0, up_q[31:0]} + {1'b0, m_q}) : {1'b0, up_q[31:0]};
  assign r2  = {up_q[31:0], bt_q[31]};
  assign df  = r2 - {1'b0, m_q};
  assign neg = 64'(-{up_q[31:0], bt_q});

  // step sequencing
  always_comb begin
    st_d = st_q; up_d = up_q; bt_d = bt_q; m_d = m_q; cnt_d = cnt_q;
    nq_d = nq_q; nr_d = nr_q; div_d = div_q; two_d = two_q; done_d = 1'b0;
    unique case (st_q)
      pqu_pkg::ENG_IDLE: begin
        if (i_start) begin
          st_d  = pqu_pkg::ENG_RUN;
          up_d  = '0;
          bt_d  = i_div ? (ma << i_skip) : mb;
          m_d   = i_div ? mb : ma;
          cnt_d = i_steps;
          nq_d  = i_signed & (i_a[31] ^ i_b[31]);
          nr_d  = i_signed & i_div & i_a[31];
          div_d = i_div;
          two_d = i_two_fix;
        end
      end
      pqu_pkg::ENG_RUN: begin
        if (div_q) begin
          up_d = df[32] ? r2 : df;
          bt_d = {bt_q[30:0], ~df[32]};
        end else begin
          up_d = {1'b0, s[32:1]};
          bt_d = {s[0], bt_q[31:1]};
        end
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          if (nq_q | nr_q) begin
            st_d = pqu_pkg::ENG_FIX;
          end else begin
            st_d   = pqu_pkg::ENG_IDLE;
            done_d = 1'b1;
          end
        end
      end
      pqu_pkg::ENG_FIX: begin
        if (!div_q) begin
          if (nq_q) begin
            {up_d[31:0], bt_d} = neg;
          end
        end else begin
          if (nq_q) begin
            bt_d = 32'(-bt_q);
          end
          if (nr_q && !two_q) begin
            up_d = {1'b0, 32'(-up_q[31:0])};
          end
        end
        if (div_q && two_q && nr_q) begin
          st_d = pqu_pkg::ENG_FIX2;
        end else begin
          st_d   = pqu_pkg::ENG_IDLE;
          done_d = 1'b1;
        end
      end
      pqu_pkg::ENG_FIX2: begin
        up_d   = {1'b0, 32'(-up_q[31:0])};
        st_d   = pqu_pkg::ENG_IDLE;
        done_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= pqu_pkg::ENG_IDLE; up_q <= '0; bt_q <= '0; m_q <= '0; cnt_q <= '0;
      nq_q <= 1'b0; nr_q <= 1'b0; div_q <= 1'b0; two_q <= 1'b0; done_q <= 1'b0;
    end else begin
      st_q <= st_d; up_q <= up_d; bt_q <= bt_d; m_q <= m_d; cnt_q <= cnt_d;
      nq_q <= nq_d; nr_q <= nr_d; div_q <= div_d; two_q <= two_d; done_q <= done_d;
    end
  end

  assign o_done = done_q;
  assign o_up   = up_q[31:0];
  assign o_bt   = bt_q;
endmodule

// file: pqu_unit.sv
// Contract
// - runs beside integer pipeline, never stalled
// - one pair, or four with option
// - moves copy upper/bottom half to register
// - three styles; option forces full array
// - option: one product per clock, array
// - option: extra pairs and pair shift
// - option products: latency 5, repeat 1
// - booth: primary 32 bits, secondary 16
// - pass count from secondary operand only
// - booth: two-pass pair products every other clock, register form every third
// - operand size found by hardware itself
// - booth holds pair, divider, sequencing
// - option: all product forms 5/1
// - option divide timing by dividend width
// - booth product timings 5/2 6/3 2/1 3/2
// - booth divide timing by dividend width
// - iterative: one bit per clock, stalls
// - iterative timings 35/32 32 34 33
// - array and booth divide skips 23/15/7 steps early
// - busy divide takes one request into slot, stalls any further issue
`timescale 1ns/1ps
module pqu_unit #(
  parameter pqu_pkg::pqu_style_t STYLE = pqu_pkg::STYLE_ARRAY,
  parameter bit                  DSP   = 1'b1
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_rst_n,
  input  wire pqu_pkg::pqu_issue_t i_issue,
  output logic                     o_ready,
  output pqu_pkg::pqu_wb_t         o_wb,
  output logic                     o_busy
);
  // ----------------------------------------------------------------
  // build style
  // ----------------------------------------------------------------
  // option forces array
  localparam pqu_pkg::pqu_style_t EFF = DSP ? pqu_pkg::STYLE_ARRAY : STYLE;

  pqu_pkg::pqu_slot_t slot_q, slot_d;
  pqu_pkg::pqu_line_t line_q, line_d;
  pqu_pkg::pqu_rec_t  nrec, srec_q, srec_d;
  pqu_pkg::pqu_seq_t  seq_q, seq_d;
  pqu_pkg::pqu_wb_t   wb_q, wb_d;
  logic [31:0] up_q [pqu_pkg::NPAIR];
  logic [31:0] up_d [pqu_pkg::NPAIR];
  logic [31:0] bt_q [pqu_pkg::NPAIR];
  logic [31:0] bt_d [pqu_pkg::NPAIR];
  logic [2:0]  cool_q, cool_d, pad_q, pad_d;
  logic        ready_q, ready_d, busy_q, busy_d;
  logic        take, disp, eng_go, eng_done, seq_ins;
  logic [1:0]  in_pcls, in_scls;
  logic [5:0]  skip;
  logic [31:0] eng_up, eng_bt;
  logic signed [32:0] ax;
  logic signed [65:0] p1, p2;
  logic [63:0] prod, pv, sh;
  logic [5:0]  amt;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_prod(pqu_pkg::pqu_op_t op);
    return op inside {[pqu_pkg::OP_PROD_REG : pqu_pkg::OP_DED_U]};
  endfunction

  function automatic logic op_signed(pqu_pkg::pqu_op_t op);
    return op inside {pqu_pkg::OP_PROD_REG, pqu_pkg::OP_PROD_S, pqu_pkg::OP_ACC_S,
                      pqu_pkg::OP_DED_S, pqu_pkg::OP_QUO_S};
  endfunction

  function automatic pqu_pkg::pqu_acc_t acc_of(pqu_pkg::pqu_op_t op);
    if (op inside {pqu_pkg::OP_ACC_S, pqu_pkg::OP_ACC_U}) return pqu_pkg::ACC_ADD;
    if (op inside {pqu_pkg::OP_DED_S, pqu_pkg::OP_DED_U}) return pqu_pkg::ACC_SUB;
    return pqu_pkg::ACC_NONE;
  endfunction

  function automatic logic on_seq(pqu_pkg::pqu_op_t op);
    return (op inside {pqu_pkg::OP_QUO_S, pqu_pkg::OP_QUO_U}) ||
           (EFF == pqu_pkg::STYLE_ITER && is_prod(op));
  endfunction

  function automatic logic two_pass(pqu_pkg::pqu_slot_t s);
    return EFF == pqu_pkg::STYLE_BOOTH && s.scls > pqu_pkg::CLS_16;
  endfunction

  function automatic logic [2:0] delay_of(pqu_pkg::pqu_slot_t s);
    if (s.iss.op inside {pqu_pkg::OP_MOVE_UP, pqu_pkg::OP_MOVE_BT}) return pqu_pkg::MOVE_LAT;
    if (EFF != pqu_pkg::STYLE_BOOTH) return pqu_pkg::ARR_LAT;
    if (s.iss.op == pqu_pkg::OP_PROD_REG)
      return two_pass(s) ? pqu_pkg::BTH_REG_LAT2 : pqu_pkg::BTH_REG_LAT1;
    return two_pass(s) ? pqu_pkg::BTH_PAIR_LAT2 : pqu_pkg::BTH_PAIR_LAT1;
  endfunction

  function automatic logic [2:0] rep_of(pqu_pkg::pqu_slot_t s);
    if (EFF != pqu_pkg::STYLE_BOOTH) return pqu_pkg::ARR_REP;
    if (s.iss.op == pqu_pkg::OP_PROD_REG)
      return two_pass(s) ? pqu_pkg::BTH_REG_REP2 : pqu_pkg::BTH_REG_REP1;
    return two_pass(s) ? pqu_pkg::BTH_PAIR_REP2 : pqu_pkg::BTH_PAIR_REP1;
  endfunction

  // pending pair write at or above a line position
  function automatic logic pend(pqu_pkg::pqu_line_t ln, logic [1:0] p, logic [2:0] k);
    logic r;
    r = 1'b0;
    for (int i = 0; i < pqu_pkg::DEPTH; i++) begin
      if (i >= int'(k) && ln[i].valid && !ln[i].to_reg && ln[i].pair == p) r = 1'b1;
    end
    return r;
  endfunction

  function automatic logic blocked(pqu_pkg::pqu_slot_t s, pqu_pkg::pqu_line_t ln,
                                   logic sbusy, logic [2:0] cool);
    logic [2:0] d;
    logic       b;
    pqu_pkg::pqu_op_t op;
    op = s.iss.op;
    d  = delay_of(s);
    b  = 1'b0;
    if (sbusy) b = 1'b1;
    if (on_seq(op)) begin
      b = b | pend(ln, s.iss.pair, 3'h0);
    end else if (op != pqu_pkg::OP_NONE) begin
      if (ln[d].valid) b = 1'b1;
      if (op inside {pqu_pkg::OP_MOVE_UP, pqu_pkg::OP_MOVE_BT, pqu_pkg::OP_PAIR_SHIFT} ||
          acc_of(op) != pqu_pkg::ACC_NONE) b = b | pend(ln, s.iss.pair, 3'h0);
      if (op != pqu_pkg::OP_PROD_REG) b = b | pend(ln, s.iss.pair, d - 3'h1);
      if (is_prod(op) && cool != 3'h0) b = 1'b1;
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // size classes and engine
  // ----------------------------------------------------------------
  // hardware size detection
  pqu_width u_pcls (
    .i_value  (i_issue.primary_operand),
    .i_signed (op_signed(i_issue.op)),
    .o_cls    (in_pcls)
  );

  pqu_width u_scls (
    .i_value  (i_issue.secondary_operand),
    .i_signed (op_signed(i_issue.op)),
    .o_cls    (in_scls)
  );

  always_comb begin
    unique case (slot_q.pcls)
      pqu_pkg::CLS_8:  skip = pqu_pkg::SKIP_8;
      pqu_pkg::CLS_16: skip = pqu_pkg::SKIP_16;
      pqu_pkg::CLS_24: skip = pqu_pkg::SKIP_24;
      default:         skip = 6'h00;
    endcase
    if (EFF == pqu_pkg::STYLE_ITER || !is_prod(slot_q.iss.op) == 1'b0) skip = 6'h00;
  end

  pqu_iter u_iter (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_start    (eng_go),
    .i_div      (!is_prod(slot_q.iss.op)),
    .i_signed   (op_signed(slot_q.iss.op)),
    .i_a        (slot_q.iss.primary_operand),
    .i_b        (slot_q.iss.secondary_operand),
    .i_steps    (is_prod(slot_q.iss.op) ? pqu_pkg::FULL_STEPS : pqu_pkg::FULL_STEPS - skip),
    .i_skip     (skip),
    .i_two_fix  (DSP),
    .o_done     (eng_done),
    .o_up       (eng_up),
    .o_bt       (eng_bt)
  );

  // ----------------------------------------------------------------
  // datapath for dispatched record
  // ----------------------------------------------------------------
  // primary wide, secondary split in halves
  assign ax = {op_signed(slot_q.iss.op) & slot_q.iss.primary_operand[31],
               slot_q.iss.primary_operand};
  assign p1 = 66'(ax) * 66'($signed({op_signed(slot_q.iss.op) &
              slot_q.iss.secondary_operand[15], slot_q.iss.secondary_operand[15:0]}));
  assign p2 = 66'(ax) * 66'($signed({1'b0, slot_q.iss.secondary_operand[15:0]})) +
              ((66'(ax) * 66'($signed({op_signed(slot_q.iss.op) &
              slot_q.iss.secondary_operand[31], slot_q.iss.secondary_operand[31:16]})))
              <<< 16);
  assign prod = (EFF == pqu_pkg::STYLE_BOOTH && !two_pass(slot_q)) ? p1[63:0] : p2[63:0];
  assign pv   = {up_q[slot_q.iss.pair], bt_q[slot_q.iss.pair]};
  assign amt  = slot_q.iss.secondary_operand[5:0];
  // pair shift, negative amount shifts left
  assign sh   = amt[5] ? (pv << 6'(-amt)) : 64'($signed(pv) >>> amt);

  always_comb begin
    nrec        = '0;
    nrec.valid  = 1'b1;
    nrec.pair   = slot_q.iss.pair;
    nrec.acc    = acc_of(slot_q.iss.op);
    nrec.to_reg = slot_q.iss.op inside {pqu_pkg::OP_PROD_REG, pqu_pkg::OP_MOVE_UP,
                                        pqu_pkg::OP_MOVE_BT};
    {nrec.up, nrec.bt} = prod;
    if (slot_q.iss.op == pqu_pkg::OP_MOVE_UP) nrec.bt = pv[63:32];
    if (slot_q.iss.op == pqu_pkg::OP_MOVE_BT) nrec.bt = pv[31:0];
    if (slot_q.iss.op == pqu_pkg::OP_PAIR_SHIFT) {nrec.up, nrec.bt} = sh;
  end

  // ----------------------------------------------------------------
  // issue slot, result line and repeat spacing
  // ----------------------------------------------------------------
  // no input can hold the unit
  assign take    = i_issue.valid & ready_q;
  assign disp    = slot_q.iss.valid & !blocked(slot_q, line_q, seq_q != pqu_pkg::SEQ_IDLE,
                                               cool_q);
  assign eng_go  = disp & on_seq(slot_q.iss.op);
  assign seq_ins = (seq_q == pqu_pkg::SEQ_PAD) && (pad_q == 3'h0);

  always_comb begin
    slot_d = slot_q;
    if (disp) slot_d.iss.valid = 1'b0;
    if (take) begin
      slot_d.iss  = i_issue;
      slot_d.pcls = in_pcls;
      slot_d.scls = in_scls;
      if (!DSP) slot_d.iss.pair = 2'h0;
      if (!DSP && i_issue.op == pqu_pkg::OP_PAIR_SHIFT) slot_d.iss.op = pqu_pkg::OP_NONE;
    end
    for (int i = 0; i < pqu_pkg::DEPTH - 1; i++) line_d[i] = line_q[i + 1];
    line_d[pqu_pkg::DEPTH-1] = '0;
    if (disp && !on_seq(slot_q.iss.op) && slot_q.iss.op != pqu_pkg::OP_NONE)
      line_d[delay_of(slot_q) - 3'h1] = nrec;
    if (seq_ins) line_d[srec_q.to_reg ? pqu_pkg::ITER_REG_XTRA - 3'h1 : 3'h0] = srec_q;
    cool_d = (cool_q != 3'h0) ? cool_q - 3'h1 : 3'h0;
    if (disp && is_prod(slot_q.iss.op) && !on_seq(slot_q.iss.op))
      cool_d = rep_of(slot_q) - 3'h1;
    ready_d = !slot_d.iss.valid ||
              !blocked(slot_d, line_d, seq_d != pqu_pkg::SEQ_IDLE, cool_d);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slot_q  <= '0;
      line_q  <= '0;
      cool_q  <= 3'h0;
      ready_q <= 1'b1;
    end else begin
      slot_q  <= slot_d;
      line_q  <= line_d;
      cool_q  <= cool_d;
      ready_q <= ready_d;
    end
  end

  // ----------------------------------------------------------------
  // sequencer for divide and iterative products
  // ----------------------------------------------------------------
  always_comb begin
    seq_d  = seq_q;
    srec_d = srec_q;
    pad_d  = pad_q;
    unique case (seq_q)
      pqu_pkg::SEQ_IDLE: begin
        if (eng_go) begin
          seq_d       = pqu_pkg::SEQ_RUN;
          srec_d      = nrec;
          srec_d.acc  = acc_of(slot_q.iss.op);
          if (is_prod(slot_q.iss.op)) begin
            pad_d = (acc_of(slot_q.iss.op) != pqu_pkg::ACC_NONE) ? pqu_pkg::ITER_ACC_PAD : 3'h0;
          end else begin
            pad_d = (EFF == pqu_pkg::STYLE_ARRAY) ? pqu_pkg::DIV_PAD_ARR :
                    (EFF == pqu_pkg::STYLE_BOOTH) ? pqu_pkg::DIV_PAD_BTH : pqu_pkg::DIV_PAD_ITER;
          end
        end
      end
      pqu_pkg::SEQ_RUN: begin
        if (eng_done) begin
          seq_d     = pqu_pkg::SEQ_PAD;
          srec_d.up = eng_up;
          srec_d.bt = eng_bt;
        end
      end
      pqu_pkg::SEQ_PAD: begin
        if (pad_q == 3'h0) seq_d = pqu_pkg::SEQ_IDLE;
        else pad_d = pad_q - 3'h1;
      end
      default: seq_d = pqu_pkg::SEQ_IDLE;
    endcase
    busy_d = seq_d != pqu_pkg::SEQ_IDLE;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_q  <= pqu_pkg::SEQ_IDLE;
      srec_q <= '0;
      pad_q  <= 3'h0;
      busy_q <= 1'b0;
    end else begin
      seq_q  <= seq_d;
      srec_q <= srec_d;
      pad_q  <= pad_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // result pairs and register write-back
  // ----------------------------------------------------------------
  always_comb begin
    logic [63:0] cur;
    cur  = {up_q[line_q[0].pair], bt_q[line_q[0].pair]};
    wb_d = '0;
    for (int i = 0; i < pqu_pkg::NPAIR; i++) begin
      up_d[i] = up_q[i];
      bt_d[i] = bt_q[i];
    end
    if (line_q[0].valid && line_q[0].to_reg) begin
      wb_d = {1'b1, line_q[0].bt};
    end else if (line_q[0].valid) begin
      unique case (line_q[0].acc)
        pqu_pkg::ACC_ADD: cur = cur + {line_q[0].up, line_q[0].bt};
        pqu_pkg::ACC_SUB: cur = cur - {line_q[0].up, line_q[0].bt};
        default:          cur = {line_q[0].up, line_q[0].bt};
      endcase
      {up_d[line_q[0].pair], bt_d[line_q[0].pair]} = cur;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < pqu_pkg::NPAIR; i++) begin
        up_q[i] <= 32'h0000_0000;
        bt_q[i] <= 32'h0000_0000;
      end
      wb_q <= '0;
    end else begin
      for (int i = 0; i < pqu_pkg::NPAIR; i++) begin
        up_q[i] <= up_d[i];
        bt_q[i] <= bt_d[i];
      end
      wb_q <= wb_d;
    end
  end

  assign o_ready = ready_q;
  assign o_wb    = wb_q;
  assign o_busy  = busy_q;
endmodule

// file: pqu_unit_asserts.sv
`timescale 1ns/1ps
module pqu_unit_asserts (
  input wire logic                i_core_clk,
  input wire logic                i_rst_n,
  input wire pqu_pkg::pqu_issue_t i_issue,
  input wire logic                o_ready,
  input wire pqu_pkg::pqu_wb_t    o_wb,
  input wire logic                o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic tk, tk_q, tk_m, tk_r;
  logic [5:0] busy_q, age_q;
  // request taken at this edge, by kind
  assign tk = i_issue.valid && o_ready;
  assign tk_q = tk && (i_issue.op inside {pqu_pkg::OP_QUO_S, pqu_pkg::OP_QUO_U});
  assign tk_m = tk && (i_issue.op inside {pqu_pkg::OP_MOVE_UP, pqu_pkg::OP_MOVE_BT});
  assign tk_r = tk && (i_issue.op == pqu_pkg::OP_PROD_REG);
  // busy run length and age of the last result request
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 6'h00;
      age_q  <= 6'h3F;
    end else begin
      busy_q <= o_busy ? busy_q + 6'h01 : 6'h00;
      age_q  <= (tk_m || tk_r) ? 6'h00 : ((age_q == 6'h3F) ? age_q : age_q + 6'h01);
    end
  end
  property p_rst_idle; $rose(i_rst_n) |-> o_ready && !o_busy && !o_wb.valid; endproperty
  property p_reg_lat; tk_r && !o_busy |-> ##[6:14] o_wb.valid; endproperty
  property p_mv_lat; tk_m && !o_busy |-> ##[2:12] o_wb.valid; endproperty
  property p_div_busy; tk_q && !o_busy |-> ##[1:8] o_busy; endproperty
  property p_busy_min; $rose(o_busy) |-> o_busy [*8]; endproperty
  property p_busy_max; busy_q < 6'h2D; endproperty
  property p_busy_end; $fell(o_busy) |-> ##[0:8] o_ready; endproperty
  property p_wb_cause; o_wb.valid |-> age_q < 6'h32; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  a_reg_lat: assert property (p_reg_lat) else $error("register product late");
  a_mv_lat: assert property (p_mv_lat) else $error("move result late");
  a_div_busy: assert property (p_div_busy) else $error("divide not busy");
  a_busy_min: assert property (p_busy_min) else $error("divide too short");
  a_busy_max: assert property (p_busy_max) else $error("divide too long");
  a_busy_end: assert property (p_busy_end) else $error("stall after divide");
  a_wb_cause: assert property (p_wb_cause) else $error("result without request");
  c_div: cover property (tk_q ##[1:8] o_busy);
  c_mv: cover property (tk_m ##[2:12] o_wb.valid);
  c_end: cover property ($fell(o_busy));
endmodule
bind pqu_unit pqu_unit_asserts chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_issue(i_issue), .o_ready(o_ready), .o_wb(o_wb), .o_busy(o_busy));

// file: pqu_issuer.sv
`timescale 1ns/1ps
// integer pipeline side: holds each request until the unit takes it
module pqu_issuer (
  input  wire logic           i_core_clk,
  input  wire logic           i_ready,
  output pqu_pkg::pqu_issue_t o_issue
);
  initial o_issue = '0;
  // raise a request after an edge, hold it until the taking edge
  task automatic issue(input pqu_pkg::pqu_op_t op, input logic [1:0] p,
                       input logic [31:0] a, input logic [31:0] b, output int n);
    logic r;
    n = 0;
    #1;
    o_issue = {1'b1, op, p, a, b};
    // ready is settled mid-cycle and holds through the next rising edge
    do begin
      @(negedge i_core_clk);
      r = i_ready;
      @(posedge i_core_clk);
      n++;
    end while (r !== 1'b1 && n < 200);
  endtask
  // drop the request; operands no longer hold their value
  task automatic idle();
    #1;
    o_issue.valid = 1'b0;
    o_issue.primary_operand = ~o_issue.primary_operand;
    o_issue.secondary_operand = ~o_issue.secondary_operand;
  endtask
endmodule

// file: pqu_unit_tb.sv
`timescale 1ns/1ps
module pqu_unit_tb;
  logic                i_core_clk = 1'b0;
  logic                i_rst_n = 1'b0;
  logic                o_ready, o_busy;
  pqu_pkg::pqu_issue_t i_issue;
  pqu_pkg::pqu_wb_t    o_wb;
  logic signed [63:0]  pe [4];
  int                  n_errors = 0, total_checks = 0, w;
  always #2.5 i_core_clk = ~i_core_clk;
  pqu_issuer iss_u (.i_core_clk(i_core_clk), .i_ready(o_ready), .o_issue(i_issue));
  pqu_unit #(.STYLE(pqu_pkg::STYLE_ARRAY), .DSP(1'b1)) dut_u (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_issue(i_issue), .o_ready(o_ready), .o_wb(o_wb), .o_busy(o_busy));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // wait for a register result, counting edges
  task automatic get_wb(output logic [31:0] d, output int n);
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (o_wb.valid !== 1'b1 && n < 80);
    d = o_wb.data;
    @(posedge i_core_clk);
  endtask
  // move one half of a pair out and compare it
  task automatic rd(input pqu_pkg::pqu_op_t op, input int p, input logic [31:0] e);
    logic [31:0] d;
    int n;
    iss_u.issue(op, 2'(p), 32'h0, 32'h0, w);
    iss_u.idle();
    get_wb(d, n);
    chk("moved half", d, e);
  endtask
  // four pairs written on consecutive edges, read back at once
  task automatic s_pairs();
    int t;
    t = 0;
    for (int p = 0; p < 4; p++) begin
      pe[p] = $signed(32'hFFFF_0001 + 32'(p)) * $signed(32'h0007_0003);
      iss_u.issue(pqu_pkg::OP_PROD_S, 2'(p), 32'hFFFF_0001 + 32'(p), 32'h0007_0003, w);
      t += w;
    end
    iss_u.idle();
    chk("issue edges", 32'(t), 32'h4);
    for (int p = 0; p < 4; p++) begin
      rd(pqu_pkg::OP_MOVE_BT, p, pe[p][31:0]);
      rd(pqu_pkg::OP_MOVE_UP, p, pe[p][63:32]);
    end
  endtask
  // dependent accumulate then deduct on one pair
  task automatic s_acc();
    iss_u.issue(pqu_pkg::OP_ACC_U, 2'h1, 32'hFFFF_FFFF, 32'h0000_0010, w);
    iss_u.issue(pqu_pkg::OP_DED_S, 2'h1, 32'hFFFF_FFFE, 32'h0000_0300, w);
    iss_u.idle();
    pe[1] = pe[1] + 64'h0000_000F_FFFF_FFF0 + 64'h0000_0000_0000_0600;
    rd(pqu_pkg::OP_MOVE_BT, 1, pe[1][31:0]);
    rd(pqu_pkg::OP_MOVE_UP, 1, pe[1][63:32]);
  endtask
  // product to register, value and latency
  task automatic s_reg();
    logic [31:0] d;
    int n;
    iss_u.issue(pqu_pkg::OP_PROD_REG, 2'h0, 32'h0001_2345, 32'hFFFF_FFFD, w);
    iss_u.idle();
    get_wb(d, n);
    chk("reg product", d, 32'hFFFC_9631);
    chk("reg latency", 32'(n >= 6 && n <= 7), 32'h1);
  endtask
  // divide into pair 2, measuring how long the sequencer stays busy
  task automatic quo(input pqu_pkg::pqu_op_t op, input logic [31:0] a, output int l);
    l = 0;
    iss_u.issue(op, 2'h2, a, a[31] ? 32'h7 : 32'h10, w);
    iss_u.idle();
    for (int i = 0; i < 8 && o_busy !== 1'b1; i++) @(posedge i_core_clk);
    while (o_busy === 1'b1 && l < 60) begin
      @(posedge i_core_clk);
      l++;
    end
  endtask
  // short signed dividend against full unsigned dividend
  task automatic s_div();
    int l8, l32;
    quo(pqu_pkg::OP_QUO_S, 32'hFFFF_FF9C, l8);
    rd(pqu_pkg::OP_MOVE_BT, 2, 32'hFFFF_FFF2);
    rd(pqu_pkg::OP_MOVE_UP, 2, 32'hFFFF_FFFE);
    quo(pqu_pkg::OP_QUO_U, 32'h7FFF_FFF0, l32);
    rd(pqu_pkg::OP_MOVE_BT, 2, 32'h07FF_FFFF);
    chk("skip span", 32'(l32 - l8 >= 20 && l32 - l8 <= 25), 32'h1);
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_core_clk);
    #1 i_rst_n = 1'b1;
    @(posedge i_core_clk);
    s_pairs();
    s_acc();
    s_reg();
    s_div();
    summarize();
  end
  // hang guard, well beyond the expected run
  initial begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule
